// *** core/cff_pkg.sv ***
// shared constants and carriers for the channel fault flag bank
package cff_pkg;

    localparam int unsigned NUM_CH        = 4;            // channel count
    localparam int unsigned ADDR_W        = 5;            // register address width
    localparam int unsigned DATA_W        = 8;            // register width

    // register offsets
    localparam logic [4:0] OPEN_WIRE_FAULT_FLAGS_ADDR    = 5'h05;
    localparam logic [4:0] SUPPLY_SHORT_FAULT_FLAGS_ADDR = 5'h06;

    // reset values
    localparam logic [7:0] OPEN_WIRE_FAULT_FLAGS_RST    = 8'h00;
    localparam logic [7:0] SUPPLY_SHORT_FAULT_FLAGS_RST = 8'h00;

    // field positions: low nibble and high nibble
    localparam int unsigned LO_LSB = 0;
    localparam int unsigned HI_LSB = 4;

    // above-supply stretch time and clock rate
    localparam longint unsigned STRETCH_NS = 64'd10700000;  // 10.7 ms
    localparam longint unsigned CLK_PERIOD_NS = 64'd8;      // 125 MHz
    // least time: round up
    localparam longint unsigned STRETCH_CYC =
        (STRETCH_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

    // per-channel raw detector inputs
    typedef struct packed {
        logic [3:0] open_wire;       // open-wire comparator, per channel
        logic [3:0] above_supply;    // above-supply comparator, per channel
        logic [3:0] short_supply;    // short-to-supply comparator, per channel
        logic [3:0] supply_ov;       // channel supply above threshold
    } cff_detect_t;

    // per-channel mode view
    typedef struct packed {
        logic [3:0] hs_mode;         // channel is a high-side output
        logic [3:0] switch_on;       // high-side switch is on
    } cff_chan_t;

    // register read port
    typedef struct packed {
        logic       rd;              // one-cycle read strobe
        logic [4:0] addr;            // register address
    } cff_rd_req_t;

endpackage

// *** core/cff_flag_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module cff_flag_bank #(
    parameter longint unsigned STRETCH_CYCLES = cff_pkg::STRETCH_CYC  // above-supply hold
) (
    // clock and reset
    input  wire logic                 sys_clk_in,    // 125 MHz clock
    input  wire logic                 nrst_in,       // async reset, active low
    // fault side: raw detectors, channel state and latch setting
    input  wire cff_pkg::cff_detect_t detect_in,     // raw detectors, asynchronous
    input  wire cff_pkg::cff_chan_t   chan_in,       // channel mode, same clock
    input  wire logic                 fault_latch_enable_in, // global latch setting
    // host read port
    input  wire cff_pkg::cff_rd_req_t rd_req_in,     // register read request
    output logic [7:0]                rd_data_out,   // read data, one cycle after strobe
    output logic                      rd_valid_out,  // read data valid pulse
    // register contents, shown live
    output logic [7:0]                open_wire_fault_flags_out,    // live register view
    output logic [7:0]                supply_short_fault_flags_out  // live register view
);

    localparam int unsigned DW = $bits(cff_pkg::cff_detect_t);  // detector bus width
    localparam logic [7:0]  UNMAPPED_DATA = 8'h00;                // read value off the map

    // data path, one register stage per edge:
    //   detect_in -> sync1 -> sync2 -> sync3 -> stable (stages 2 and 3 agree)
    //   stable -> conditions (gated by channel mode, stretched for above-supply)
    //   conditions -> flag registers (live or sticky, per fault_latch_enable_in)
    // a detector change so reaches the flag outputs five edges later, and a
    // pulse shorter than two cycles never reaches them at all: that is the
    // glitch filter that the agreement rule buys, at the price of latency
    // the host reads with a one-cycle strobe and gets its answer one edge
    // later; a read and a fault in the same cycle leave the fault standing

    // three-stage synchroniser for the detector bus
    logic [DW-1:0] sync1;   // first stage, read only by sync2
    logic [DW-1:0] sync2;   // second stage
    logic [DW-1:0] sync3;   // third stage
    logic [DW-1:0] stable;  // accepted level once stages 2 and 3 agree

    // stretch counters for the above-supply channels
    logic [31:0] stretch_cnt [cff_pkg::NUM_CH];

    cff_pkg::cff_detect_t det;       // filtered detectors
    logic [3:0] cond_ow;             // open-wire condition after gating
    logic [3:0] cond_above;          // above-supply condition after stretch
    logic [3:0] cond_short;          // short condition after gating
    logic [3:0] cond_ov;             // overvoltage condition
    logic       rd_ow;               // read of open-wire register
    logic       rd_sh;               // read of short register
    logic [7:0] cond_ow_reg;         // conditions in open-wire register order
    logic [7:0] cond_sh_reg;         // conditions in short register order
    logic [7:0] next_ow;             // next open-wire register
    logic [7:0] next_sh;             // next short register

    // next flag value: live, or sticky with clear-on-read of absent faults;
    // with the latch on, a read of the register replaces the sticky value by
    // the condition of that same cycle, so a fault still present wins over
    // the clear and a read never loses an event that coincides with it
    function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                             input logic [7:0] cond,
                                             input logic       latch,
                                             input logic       rd);
        if (!latch) begin
            flag_next = cond;
        end else if (rd) begin
            flag_next = cond;
        end else begin
            flag_next = cur | cond;
        end
    endfunction

    // register select: strobe present and address matches
    function automatic logic addr_hit(input cff_pkg::cff_rd_req_t req,
                                      input logic [4:0]           addr);
        addr_hit = req.rd && (req.addr == addr);
    endfunction

    // detector synchroniser chain; the first stage may go metastable, so
    // nothing but the second stage ever reads it
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // all stages start at the idle low level of the detectors
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= detect_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // accept a bit change only when stages 2 and 3 agree
    // a bit on which they differ keeps its last accepted level
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stable <= '0;
        end else begin
            // bits are judged one by one, so channels settle independently
            for (int i = 0; i < DW; i++) begin
                if (sync2[i] == sync3[i]) begin
                    stable[i] <= sync3[i];
                end
            end
        end
    end

    // view the accepted levels through the detector struct
    assign det = cff_pkg::cff_detect_t'(stable);

    // above-supply stretch: reload on detection, count down after;
    // the detection cycle plus STRETCH_CYCLES-1 counted cycles keeps the
    // flag condition up for at least STRETCH_CYCLES cycles, however short
    // the accepted detector pulse was
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int c = 0; c < cff_pkg::NUM_CH; c++) begin
                // nothing to stretch after reset
                stretch_cnt[c] <= 32'h0;
            end
        end else begin
            for (int c = 0; c < cff_pkg::NUM_CH; c++) begin
                if (det.above_supply[c]) begin
                    stretch_cnt[c] <= 32'(STRETCH_CYCLES - 64'd1);
                end else if (stretch_cnt[c] != 32'h0) begin
                    stretch_cnt[c] <= stretch_cnt[c] - 32'h1;
                end
            end
        end
    end

    // fault conditions as seen by the flags; channel mode comes from logic
    // on this clock, so it gates the synchronised detectors directly and a
    // channel that is not a high-side output with its switch off cannot
    // raise an open-wire or short flag
    always_comb begin
        for (int c = 0; c < cff_pkg::NUM_CH; c++) begin
            cond_above[c] = det.above_supply[c] || (stretch_cnt[c] != 32'h0);
        end
        cond_ow    = det.open_wire & chan_in.hs_mode & ~chan_in.switch_on;
        cond_short = det.short_supply & chan_in.hs_mode & ~chan_in.switch_on;
        cond_ov    = det.supply_ov;
        cond_ow_reg = {cond_above, cond_ow};   // [7:4] above-supply, [3:0] open-wire
        cond_sh_reg = {cond_ov, cond_short};   // [7:4] overvoltage, [3:0] short
    end

    // read decode; an unmapped address selects neither register
    assign rd_ow = addr_hit(rd_req_in, cff_pkg::OPEN_WIRE_FAULT_FLAGS_ADDR);
    assign rd_sh = addr_hit(rd_req_in, cff_pkg::SUPPLY_SHORT_FAULT_FLAGS_ADDR);

    // next register contents
    // both registers share one update rule; only their conditions and read selects differ
    always_comb begin
        next_ow = flag_next(open_wire_fault_flags_out, cond_ow_reg,
                            fault_latch_enable_in, rd_ow);
        next_sh = flag_next(supply_short_fault_flags_out, cond_sh_reg,
                            fault_latch_enable_in, rd_sh);
    end

    // open-wire flag register: above-supply in [7:4], open-wire in [3:0]
    // (channel 4 down to channel 1); updated every cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // documented reset value
            open_wire_fault_flags_out <= cff_pkg::OPEN_WIRE_FAULT_FLAGS_RST;
        end else begin
            open_wire_fault_flags_out <= next_ow;
        end
    end

    // short-flag register: overvoltage in [7:4], short in [3:0]
    // (channel 4 down to channel 1); updated every cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // documented reset value
            supply_short_fault_flags_out <= cff_pkg::SUPPLY_SHORT_FAULT_FLAGS_RST;
        end else begin
            supply_short_fault_flags_out <= next_sh;
        end
    end

    // read valid: every strobe is answered one edge later, mapped or not
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // no answer pending after reset
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_req_in.rd;
        end
    end

    // read data: value held before the clear takes effect, so the host sees
    // the event that the same read clears; the data stands for one cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // idle data level
            rd_data_out <= UNMAPPED_DATA;
        end else if (rd_ow) begin
            rd_data_out <= open_wire_fault_flags_out;
        end else if (rd_sh) begin
            rd_data_out <= supply_short_fault_flags_out;
        end else begin
            rd_data_out <= UNMAPPED_DATA;                 // unmapped or idle reads as zero
        end
    end

    // limitation: the stretch counter is 32 bits wide, ample for the default
    // interval; a STRETCH_CYCLES of zero is not meaningful and is not guarded

endmodule

`default_nettype wire

// *** tb/cff_flag_bank_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the flag bank
module cff_flag_bank_sva (
    input wire logic                 sys_clk_in,
    input wire logic                 nrst_in,
    input wire cff_pkg::cff_chan_t   chan_in,
    input wire logic                 fault_latch_enable_in,
    input wire cff_pkg::cff_rd_req_t rd_req_in,
    input wire logic [7:0]           rd_data_out,
    input wire logic                 rd_valid_out,
    input wire logic [7:0]           open_wire_fault_flags_out,
    input wire logic [7:0]           supply_short_fault_flags_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    logic [3:0] gate;  // channels allowed to raise low-nibble flags
    assign gate = chan_in.hs_mode & ~chan_in.switch_on;
    a_valid_after_rd: assert property (rd_req_in.rd |=> rd_valid_out)
        else $error("no valid after read");
    a_valid_only_rd: assert property (rd_valid_out |-> $past(rd_req_in.rd))
        else $error("valid without read");
    a_ow_rd_data: assert property (rd_req_in.rd && rd_req_in.addr == 5'h05
        |=> rd_data_out == $past(open_wire_fault_flags_out)) else $error("bad open-wire read");
    a_sh_rd_data: assert property (rd_req_in.rd && rd_req_in.addr == 5'h06
        |=> rd_data_out == $past(supply_short_fault_flags_out)) else $error("bad short read");
    a_ow_gate: assert property ((open_wire_fault_flags_out[3:0] & ~$past(gate)
        & ~$past(open_wire_fault_flags_out[3:0])) == 4'h0) else $error("open-wire set ungated");
    a_sh_gate: assert property ((supply_short_fault_flags_out[3:0] & ~$past(gate)
        & ~$past(supply_short_fault_flags_out[3:0])) == 4'h0) else $error("short set ungated");
    a_ow_latch_hold: assert property ($past(fault_latch_enable_in) && !($past(rd_req_in.rd)
        && $past(rd_req_in.addr) == 5'h05) |-> ($past(open_wire_fault_flags_out)
        & ~open_wire_fault_flags_out) == 8'h00) else $error("open-wire latch dropped");
    a_sh_latch_hold: assert property ($past(fault_latch_enable_in) && !($past(rd_req_in.rd)
        && $past(rd_req_in.addr) == 5'h06) |-> ($past(supply_short_fault_flags_out)
        & ~supply_short_fault_flags_out) == 8'h00) else $error("short latch dropped");
    c_ow_read: cover property (rd_req_in.rd && rd_req_in.addr == 5'h05);
    c_sh_read: cover property (rd_req_in.rd && rd_req_in.addr == 5'h06);
    c_latch_clear: cover property (fault_latch_enable_in && $fell(open_wire_fault_flags_out[1]));
    c_stretch_end: cover property ($fell(open_wire_fault_flags_out[7]));
endmodule
bind cff_flag_bank cff_flag_bank_sva i_cff_flag_bank_sva (.sys_clk_in, .nrst_in, .chan_in,
    .fault_latch_enable_in, .rd_req_in, .rd_data_out, .rd_valid_out,
    .open_wire_fault_flags_out, .supply_short_fault_flags_out);
`default_nettype wire

// *** tb/cff_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side: issues single-cycle register reads
module cff_host_model (
    input wire logic                clk_in,
    output var cff_pkg::cff_rd_req_t rd_req_out,
    input wire logic [7:0]          rd_data_in,
    input wire logic                rd_valid_in
);
    initial rd_req_out = '0;
    // strobe one cycle, take data at the edge that sees valid
    task automatic read(input logic [4:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        rd_req_out <= {1'b1, addr};
        @(posedge clk_in);
        rd_req_out <= {1'b0, ~addr};  // released address shows junk
        @(posedge clk_in);
        data = rd_valid_in ? rd_data_in : 8'hxx;
    endtask
endmodule
`default_nettype wire

// *** tb/cff_flag_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cff_flag_bank_bench;
    logic                 clk = 1'b0;     // 125 MHz bench clock
    logic                 nrst = 1'b0;    // reset, active low
    logic                 latch = 1'b0;   // global latch setting
    cff_pkg::cff_detect_t det = '0;       // raw detectors
    cff_pkg::cff_chan_t   chan = 8'hf0;   // high-side, switches off
    cff_pkg::cff_rd_req_t rd_req;
    logic [7:0]           rd_data, ow, sh, got;
    logic                 rd_valid;
    int                   error_cnt = 0;
    int                   checks = 0;
    always #4 clk = ~clk;
    cff_flag_bank #(.STRETCH_CYCLES(64'd20)) i_cff_flag_bank (.sys_clk_in(clk),
        .nrst_in(nrst), .detect_in(det), .chan_in(chan), .fault_latch_enable_in(latch),
        .rd_req_in(rd_req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .open_wire_fault_flags_out(ow), .supply_short_fault_flags_out(sh));
    cff_host_model i_cff_host_model (.clk_in(clk), .rd_req_out(rd_req),
        .rd_data_in(rd_data), .rd_valid_in(rd_valid));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [4:0] a, input logic [7:0] exp);
        i_cff_host_model.read(a, got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value rd_data at %h exp %h seen %h", a, exp, got);
        end
    endtask
    // live register view, sampled mid-cycle where it is settled
    task automatic chk_view(input logic [7:0] exp_ow, input logic [7:0] exp_sh);
        @(negedge clk);
        checks++;
        if (ow !== exp_ow || sh !== exp_sh) begin
            error_cnt++;
            $display("wrong value flag view exp %h %h seen %h %h", exp_ow, exp_sh, ow, sh);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: the tests need a few hundred cycles
    initial begin
        step(3000);
        error_cnt++;
        summarize();
    end
    initial begin
        step(10);
        nrst <= 1'b1;
        chk(5'h05, 8'h00);
        chk(5'h06, 8'h00);
        chk(5'h07, 8'h00); // unmapped
        det <= 16'h50a3;
        step(8);
        chk_view(8'h05, 8'h3a);
        chk(5'h05, 8'h05);
        chk(5'h06, 8'h3a);
        det <= '0;
        step(8);
        chk_view(8'h00, 8'h00);
        chk(5'h05, 8'h00);
        chk(5'h06, 8'h00);
        chan <= 8'hff;
        det <= 16'hf0f1;
        step(8);
        chk(5'h05, 8'h00);
        chk(5'h06, 8'h10);
        chan <= 8'h51;     // high-side on ch3 and ch1, switch on at ch1 only
        det <= 16'hf0f0;
        step(8);
        chk_view(8'h04, 8'h04);
        chk(5'h06, 8'h04);
        chan <= 8'hf0;
        det <= 16'h0800;
        step(6);
        det <= '0;
        step(10);
        chk(5'h05, 8'h80);
        step(4);
        chk_view(8'h80, 8'h00);
        step(30);
        chk(5'h05, 8'h00);
        latch <= 1'b1;
        det <= 16'h3000;
        step(8);
        det <= 16'h1000;
        step(8);
        chk_view(8'h03, 8'h00);
        chk(5'h05, 8'h03);
        chk(5'h05, 8'h01);
        det <= '0;
        step(8);
        chk(5'h05, 8'h01);
        chk(5'h05, 8'h00);
        det <= 16'h0042;
        step(8);
        det <= 16'h0002;
        step(8);
        chk(5'h06, 8'h24);
        chk(5'h06, 8'h20);
        chk_view(8'h00, 8'h20);
        step(1);
        det <= '0;
        step(8);
        chk(5'h06, 8'h20);
        chk(5'h06, 8'h00);
        det <= 16'h0001;   // overvoltage on ch1, latched
        step(8);
        nrst <= 1'b0;      // mid-run reset clears the latched bank
        step(2);
        nrst <= 1'b1;
        chk_view(8'h00, 8'h00); // reset value
        step(8);
        chk(5'h06, 8'h10);
        summarize();
    end
endmodule
`default_nettype wire
